// *** core/vss_pkg.sv ***
// Notes on behaviour
// - both lines idle high; start only when free
// - one bit per clock; data changes low
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - eight-bit bytes, then one acknowledge pulse
// - byte sender releases sda during acknowledge
// - addressed device acknowledges every received byte
// - acknowledger holds sda low through pulse
// - master reader acknowledges all but last
// - master nacks last; device releases sda
// - seven-bit address plus direction bit
// - direction zero writes, one reads
// - address byte first after every start
// - read right after address returns status
// - master nack ends device transmission
// - array read: address, command, two addresses
// - device allows direction change mid command
// - array read supplies bytes without limit
// - byte count per transfer is unbounded
package vss_pkg;
    localparam logic [6:0] VSS_DEV_ADDR = 7'h40; // arbitrary default
    localparam int VSS_ADDR_BITS = 7;
    localparam int VSS_BYTE_BITS = 8;
    localparam int VSS_RW_POS = 0;
    localparam logic VSS_DIR_WRITE = 1'b0;
    localparam logic VSS_DIR_READ = 1'b1;
    localparam int VSS_HALF_CYCLES = 25;
    localparam int VSS_NUM_WBYTES = 3;
    localparam int VSS_CMD_IDX = 0;
endpackage

// *** core/vss_link_if.sv ***
`timescale 1ns/1ns
// two-wire link; open-drain levels resolved here from the enables
interface vss_link_if;
    logic scl_out;
    logic scl_oe;
    logic sda_m_oe;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // pull-ups keep both lines high when nobody drives low
    assign scl = !(scl_oe && !scl_out);
    assign sda = !(sda_m_oe || sda_s_oe);
    modport master (output scl_out, output scl_oe, output sda_m_oe,
        input scl, input sda);
    modport slave (output sda_s_oe, input scl, input sda);
endinterface

// *** core/vss_slave.sv ***
`timescale 1ns/1ns
module vss_slave
    import vss_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = VSS_DEV_ADDR
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link
    vss_link_if.slave link,
    // user side: bytes written and bytes to return
    output logic [7:0] wr_data_r,
    output logic wr_cmd_r,
    output logic wr_valid_r,
    input wire logic [7:0] stat_data,
    input wire logic [7:0] arr_data,
    output logic rd_take_r,
    output logic rd_is_array_r,
    output logic [1:0] wr_index_r,
    output logic busy_r
);
    typedef enum logic [4:0] {
        VSS_S_IDLE = 5'h01,
        VSS_S_ADDR = 5'h02,
        VSS_S_RECV = 5'h04,
        VSS_S_SEND = 5'h08,
        VSS_S_IGN = 5'h10
    } vss_state_t;

    logic [2:0] scl_sync_r;
    logic [2:0] sda_sync_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    vss_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic ack_phase_r;
    logic [7:0] tx_r;
    logic read_mode_r;
    logic wr_seen_r;

    // two flops before use; third stage only feeds edge detection
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], link.scl};
            sda_sync_r <= {sda_sync_r[1:0], link.sda};
        end
    end

    assign scl_rise = scl_sync_r[1] && !scl_sync_r[2];
    assign scl_fall = !scl_sync_r[1] && scl_sync_r[2];
    // sda edges with scl steady high are control, not data
    assign start_det = scl_sync_r[1] && scl_sync_r[2] &&
        !sda_sync_r[1] && sda_sync_r[2];
    assign stop_det = scl_sync_r[1] && scl_sync_r[2] &&
        sda_sync_r[1] && !sda_sync_r[2];

    // busy flag between start and stop
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            busy_r <= 1'b0;
        else if (start_det)
            busy_r <= 1'b1;
        else if (stop_det)
            busy_r <= 1'b0;
    end

    // main protocol state: bits sampled on scl rise
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_r <= VSS_S_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ack_phase_r <= 1'b0;
            read_mode_r <= 1'b0;
            wr_seen_r <= 1'b0;
            wr_index_r <= 2'h0;
            rd_is_array_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= VSS_S_IDLE;
            wr_seen_r <= 1'b0;
            ack_phase_r <= 1'b0;
        end else if (start_det) begin
            // repeated start keeps write history for array read
            state_r <= VSS_S_ADDR;
            bit_cnt_r <= 4'h0;
            ack_phase_r <= 1'b0;
        end else if (scl_rise) begin
            case (state_r)
                VSS_S_ADDR, VSS_S_RECV: begin
                    if (!ack_phase_r) begin
                        shift_r <= {shift_r[6:0], sda_sync_r[1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                VSS_S_SEND: begin
                    if (ack_phase_r && sda_sync_r[1])
                        state_r <= VSS_S_IGN;
                    else if (!ack_phase_r)
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_r)
                VSS_S_ADDR: begin
                    if (ack_phase_r) begin
                        ack_phase_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        if (read_mode_r) begin
                            state_r <= VSS_S_SEND;
                            // status read when no write preceded
                            rd_is_array_r <= wr_seen_r;
                        end else begin
                            state_r <= VSS_S_RECV;
                            wr_seen_r <= 1'b1;
                            wr_index_r <= 2'h0;
                        end
                    end else if (bit_cnt_r == 4'(VSS_BYTE_BITS)) begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                            ack_phase_r <= 1'b1;
                            read_mode_r <= shift_r[VSS_RW_POS];
                        end else begin
                            state_r <= VSS_S_IGN;
                        end
                    end
                end
                VSS_S_RECV: begin
                    if (ack_phase_r) begin
                        ack_phase_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        // saturating index: byte count itself unbounded
                        if (wr_index_r != 2'h3)
                            wr_index_r <= wr_index_r + 2'h1;
                    end else if (bit_cnt_r == 4'(VSS_BYTE_BITS)) begin
                        ack_phase_r <= 1'b1;
                    end
                end
                VSS_S_SEND: begin
                    if (ack_phase_r) begin
                        ack_phase_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                    end else if (bit_cnt_r == 4'(VSS_BYTE_BITS)) begin
                        ack_phase_r <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // received byte handed out once its acknowledge begins
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wr_data_r <= 8'h00;
            wr_valid_r <= 1'b0;
            wr_cmd_r <= 1'b0;
        end else begin
            wr_valid_r <= scl_fall && state_r == VSS_S_RECV &&
                !ack_phase_r && bit_cnt_r == 4'(VSS_BYTE_BITS);
            if (scl_fall && state_r == VSS_S_RECV && !ack_phase_r) begin
                wr_data_r <= shift_r;
                wr_cmd_r <= wr_index_r == 2'(VSS_CMD_IDX);
            end
        end
    end

    // transmit shifter: loaded on entering each send byte
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_r <= 8'hFF;
            rd_take_r <= 1'b0;
        end else begin
            rd_take_r <= 1'b0;
            if (scl_fall && bit_cnt_r == 4'h0 && state_r == VSS_S_SEND &&
                    !ack_phase_r) begin
                tx_r <= tx_r;
            end
            if (scl_fall && ack_phase_r &&
                    (state_r == VSS_S_SEND ||
                    (state_r == VSS_S_ADDR && read_mode_r))) begin
                tx_r <= (state_r == VSS_S_ADDR) ?
                    (wr_seen_r ? arr_data : stat_data) :
                    (rd_is_array_r ? arr_data : stat_data);
                rd_take_r <= 1'b1;
            end else if (scl_fall && state_r == VSS_S_SEND &&
                    !ack_phase_r && bit_cnt_r != 4'h0) begin
                tx_r <= {tx_r[6:0], 1'b1};
            end
        end
    end

    // open-drain drive: low for ack or a zero data bit only
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            link.sda_s_oe <= 1'b0;
        else if (start_det || stop_det)
            link.sda_s_oe <= 1'b0;
        else if (scl_fall) begin
            if ((state_r == VSS_S_ADDR || state_r == VSS_S_RECV) &&
                    !ack_phase_r && bit_cnt_r == 4'(VSS_BYTE_BITS) &&
                    (state_r == VSS_S_RECV || shift_r[7:1] == DEV_ADDR))
                link.sda_s_oe <= 1'b1;
            else if (state_r == VSS_S_ADDR && ack_phase_r && read_mode_r)
                link.sda_s_oe <= !(wr_seen_r ? arr_data[7] : stat_data[7]);
            else if (state_r == VSS_S_SEND && ack_phase_r)
                link.sda_s_oe <= !(rd_is_array_r ? arr_data[7]
                    : stat_data[7]);
            else if (state_r == VSS_S_SEND && !ack_phase_r &&
                    bit_cnt_r != 4'(VSS_BYTE_BITS))
                link.sda_s_oe <= !tx_r[6];
            else
                link.sda_s_oe <= 1'b0;
        end
    end
endmodule // vss_slave

// *** core/vss_master.sv ***
`timescale 1ns/1ns
module vss_master
    import vss_pkg::*;
#(
    parameter int HALF_CYCLES = VSS_HALF_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link
    vss_link_if.master link,
    // user command: one byte step at a time
    input wire logic op_start,
    input wire logic op_stop,
    input wire logic op_write,
    input wire logic op_read,
    input wire logic op_ack,
    input wire logic [7:0] op_data,
    output logic op_ready,
    output logic [7:0] rd_data_r,
    output logic ack_seen_r,
    output logic done_r
);
    typedef enum logic [4:0] {
        VSS_M_IDLE = 5'h01,
        VSS_M_START = 5'h02,
        VSS_M_BIT = 5'h04,
        VSS_M_ACK = 5'h08,
        VSS_M_STOP = 5'h10
    } vss_mstate_t;

    vss_mstate_t state_r;
    logic [7:0] div_r;
    logic tick;
    logic [1:0] phase_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] sh_r;
    logic rd_mode_r;
    logic ack_out_r;
    logic [1:0] sda_sync_r;

    // half-bit enable pulse divided from ref_clk
    assign tick = div_r == 8'(HALF_CYCLES - 1);
    always_ff @(posedge ref_clk) begin
        if (!rst_b || tick)
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end

    // sda from the wire crosses two flops before use
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            sda_sync_r <= 2'h3;
        else
            sda_sync_r <= {sda_sync_r[0], link.sda};
    end

    assign op_ready = state_r == VSS_M_IDLE;
    assign link.scl_oe = 1'b1;

    // phase 0: scl low, set sda; phase 1: scl high, sample
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_r <= VSS_M_IDLE;
            phase_r <= 2'h0;
            bit_cnt_r <= 4'h0;
            sh_r <= 8'hFF;
            rd_mode_r <= 1'b0;
            ack_out_r <= 1'b0;
            rd_data_r <= 8'h00;
            ack_seen_r <= 1'b0;
            done_r <= 1'b0;
            link.scl_out <= 1'b1;
            link.sda_m_oe <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                VSS_M_IDLE: begin
                    phase_r <= 2'h0;
                    if (op_start) begin
                        state_r <= VSS_M_START;
                    end else if (op_stop) begin
                        state_r <= VSS_M_STOP;
                    end else if (op_write || op_read) begin
                        state_r <= VSS_M_BIT;
                        sh_r <= op_write ? op_data : 8'hFF;
                        rd_mode_r <= !op_write;
                        ack_out_r <= op_ack;
                        bit_cnt_r <= 4'h0;
                    end
                end
                VSS_M_START: if (tick) begin
                    phase_r <= phase_r + 2'h1;
                    case (phase_r)
                        2'h0: link.sda_m_oe <= 1'b0;
                        2'h1: link.scl_out <= 1'b1;
                        2'h2: link.sda_m_oe <= 1'b1;
                        default: begin
                            link.scl_out <= 1'b0;
                            state_r <= VSS_M_IDLE;
                            done_r <= 1'b1;
                        end
                    endcase
                end
                VSS_M_BIT: if (tick) begin
                    if (!link.scl_out) begin
                        link.sda_m_oe <= !sh_r[7];
                        link.scl_out <= 1'b1;
                    end else begin
                        link.scl_out <= 1'b0;
                        sh_r <= {sh_r[6:0], sda_sync_r[1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'(VSS_BYTE_BITS - 1))
                            state_r <= VSS_M_ACK;
                    end
                end
                VSS_M_ACK: if (tick) begin
                    if (!link.scl_out) begin
                        link.sda_m_oe <= rd_mode_r && ack_out_r;
                        link.scl_out <= 1'b1;
                    end else begin
                        link.scl_out <= 1'b0;
                        ack_seen_r <= !sda_sync_r[1];
                        if (rd_mode_r)
                            rd_data_r <= sh_r;
                        state_r <= VSS_M_IDLE;
                        done_r <= 1'b1;
                    end
                end
                VSS_M_STOP: if (tick) begin
                    phase_r <= phase_r + 2'h1;
                    case (phase_r)
                        2'h0: link.sda_m_oe <= 1'b1;
                        2'h1: link.scl_out <= 1'b1;
                        default: begin
                            link.sda_m_oe <= 1'b0;
                            state_r <= VSS_M_IDLE;
                            done_r <= 1'b1;
                        end
                    endcase
                end
                default: state_r <= VSS_M_IDLE;
            endcase
        end
    end
endmodule // vss_master

// *** tb/vss_link_checker.sv ***
`timescale 1ns/1ns
module vss_link_checker
    import vss_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link drivers and resolved wires
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q_r, sda_q_r, first_r, match_r, rd_r, nack_r, rise, start;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // line edges seen on the resolved wires
    assign rise = scl && !scl_q_r;
    assign start = scl && scl_q_r && sda_q_r && !sda;
    always_ff @(posedge ref_clk) begin
        scl_q_r <= scl;
        sda_q_r <= sda;
    end
    // nine slots per byte, slot 8 is the acknowledge
    always_ff @(posedge ref_clk) begin
        if (!rst_b || start) bit_r <= 4'h0;
        else if (rise) bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (rise && bit_r != 4'h8) sh_r <= {sh_r[6:0], sda};
    end
    // transfer state; a fresh start clears it, so repeated starts count
    always_ff @(posedge ref_clk) begin
        if (!rst_b || start) begin
            first_r <= 1'b1;
            rd_r <= 1'b0;
            nack_r <= 1'b0;
        end else if (rise && bit_r == 4'h8) begin
            first_r <= 1'b0;
            if (first_r) rd_r <= sh_r[0] && sh_r[7:1] == VSS_DEV_ADDR;
            if (rd_r && sda) nack_r <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) match_r <= 1'b0;
        else if (rise && bit_r == 4'h8 && first_r)
            match_r <= sh_r[7:1] == VSS_DEV_ADDR;
    end
    property p_reset_idle;
        disable iff (1'b0) $rose(rst_b) |-> !sda_s_oe && !sda_m_oe && scl;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("lines not released after reset");
    property p_slave_stable;
        scl && scl_q_r |-> $stable(sda_s_oe);
    endproperty
    a_slave_stable: assert property (p_slave_stable)
        else $error("slave moved sda while scl high");
    property p_start_master;
        start |-> sda_m_oe && !sda_s_oe;
    endproperty
    a_start_master: assert property (p_start_master)
        else $error("start not made by master");
    property p_stop_master;
        scl && scl_q_r && !sda_q_r && sda |-> $past(sda_m_oe) && !sda_s_oe;
    endproperty
    a_stop_master: assert property (p_stop_master)
        else $error("stop not made by master");
    property p_addr_ack;
        rise && bit_r == 4'h8 && first_r && sh_r[7:1] == VSS_DEV_ADDR
            |-> sda_s_oe && !sda;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acknowledged");
    property p_write_ack;
        rise && bit_r == 4'h8 && !first_r && match_r && !rd_r |-> !sda [*4];
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("written byte not acknowledged through high phase");
    property p_ack_slot;
        !rd_r && sda_s_oe |-> bit_r == 4'h8 || bit_r == 4'h0;
    endproperty
    a_ack_slot: assert property (p_ack_slot)
        else $error("slave drove outside acknowledge slot");
    property p_foreign;
        !first_r && !match_r |-> !sda_s_oe;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("slave drove sda for foreign address");
    property p_master_ack_free;
        rd_r && rise && bit_r == 4'h8 |-> !sda_s_oe [*4];
    endproperty
    a_master_ack_free: assert property (p_master_ack_free)
        else $error("slave held sda in master acknowledge");
    property p_nack_release;
        nack_r |-> !sda_s_oe;
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("slave drove sda after not-acknowledge");
endmodule // vss_link_checker

// *** tb/voice_store_serial_slave_tb_top.sv ***
`timescale 1ns/1ns
module voice_store_serial_slave_tb_top
    import vss_pkg::*;
;
    localparam int HALF = 8; // short bit time keeps the run brief
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic op_start = 1'b0, op_stop = 1'b0, op_write = 1'b0;
    logic op_read = 1'b0, op_ack = 1'b0;
    logic [7:0] op_data = 8'h00, stat_data = 8'h00, arr_data = 8'h00;
    logic op_ready, ack_seen_r, done_r, wr_cmd_r, wr_valid_r;
    logic rd_take_r, rd_is_array_r, busy_r;
    logic [7:0] rd_data_r, wr_data_r, b;
    logic [1:0] wr_index_r;
    logic [7:0] rq[$];
    logic [8:0] wq[$];
    int miscompares = 0, num_checks = 0, n, k, wn = 0;
    logic is_arr = 1'b0;
    vss_link_if link_i();
    vss_master #(.HALF_CYCLES(HALF)) u_vss_master(.ref_clk, .rst_b,
        .link(link_i), .op_start, .op_stop, .op_write, .op_read, .op_ack,
        .op_data, .op_ready, .rd_data_r, .ack_seen_r, .done_r);
    vss_slave u_vss_slave(.ref_clk, .rst_b, .link(link_i), .wr_data_r,
        .wr_cmd_r, .wr_valid_r, .stat_data, .arr_data, .rd_take_r,
        .rd_is_array_r, .wr_index_r, .busy_r);
    vss_link_checker u_vss_link_checker(.ref_clk, .rst_b,
        .scl_out(link_i.scl_out), .scl_oe(link_i.scl_oe),
        .sda_m_oe(link_i.sda_m_oe), .sda_s_oe(link_i.sda_s_oe),
        .scl(link_i.scl), .sda(link_i.sda));
    // free running system clock
    always #5 ref_clk = ~ref_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one master step: {start, stop, write, read, ack}
    task cmd(input logic [4:0] c, input logic [7:0] d);
        {op_start, op_stop, op_write, op_read, op_ack} = c;
        op_data = d;
        n = 0;
        while (op_ready !== 1'b1) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        {op_start, op_stop, op_write, op_read, op_ack} = 5'h00;
        while (done_r !== 1'b1 && n < 4000) begin
            @(posedge ref_clk) #1;
            n++;
        end
        if (n == 4000) chk(8'h01, 8'h00);
    endtask
    task wbyte(input logic [7:0] d, input logic ack);
        cmd(5'b00100, d);
        chk({7'h00, ack_seen_r}, {7'h00, ack});
    endtask
    // the model pops the byte it saw loaded and compares
    task rbyte(input logic a);
        cmd({4'b0001, a}, 8'h00);
        if (rq.size() == 0) chk(8'h01, 8'h00);
        else chk(rd_data_r, rq.pop_front());
        chk({7'h00, rd_is_array_r}, {7'h00, is_arr});
    endtask
    task end_test(input string name);
        chk({7'h00, busy_r}, 8'h01);
        cmd(5'b01000, 8'h00);
        chk({6'h00, link_i.scl, link_i.sda}, 8'h03);
        // the slave sees the stop a few cycles late through its synchroniser
        repeat (4) @(posedge ref_clk);
        #1 chk({7'h00, busy_r}, 8'h00);
        chk(8'(wq.size()), 8'h00);
        $display("test %s done", name);
    endtask
    // model side of the user ports: record loads, feed new random bytes
    always @(posedge ref_clk) begin
        #1;
        if (rd_take_r === 1'b1) begin
            rq.push_back(is_arr ? arr_data : stat_data);
            stat_data = 8'($urandom);
            arr_data = 8'($urandom);
        end
        if (wr_valid_r === 1'b1) begin
            if (wq.size() == 0) chk(8'h01, 8'h00);
            else begin
                chk(wr_data_r, wq[0][7:0]);
                chk({7'h00, wr_cmd_r}, {7'h00, wq[0][8]});
                chk({6'h00, wr_index_r}, 8'(wn < 3 ? wn : 3));
                wn++;
                void'(wq.pop_front());
            end
        end
    end
    // hang guard, well past the expected run time
    initial begin
        #400000;
        miscompares++;
        finish_test;
    end
    initial begin
        void'($urandom(32'h7D44));
        repeat (12) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        // status read straight after the address, nack ends it
        cmd(5'b10000, 8'h00);
        wbyte({VSS_DEV_ADDR, VSS_DIR_READ}, 1'b1);
        rbyte(1'b1);
        rbyte(1'b1);
        rbyte(1'b0);
        end_test("status_read");
        // array read: command, two address bytes, repeated start, read
        rq.delete();
        cmd(5'b10000, 8'h00);
        wbyte({VSS_DEV_ADDR, VSS_DIR_WRITE}, 1'b1);
        for (k = 0; k < 3; k++) begin
            b = 8'($urandom);
            wq.push_back({k == 0, b});
            wbyte(b, 1'b1);
        end
        is_arr = 1'b1;
        cmd(5'b10000, 8'h00);
        wbyte({VSS_DEV_ADDR, VSS_DIR_READ}, 1'b1);
        for (k = 0; k < 6; k++) rbyte(k < 5);
        end_test("array_read");
        // long write, no limit on byte count
        is_arr = 1'b0;
        wn = 0;
        rq.delete();
        cmd(5'b10000, 8'h00);
        wbyte({VSS_DEV_ADDR, VSS_DIR_WRITE}, 1'b1);
        for (k = 0; k < 10; k++) begin
            b = 8'($urandom);
            wq.push_back({k == 0, b});
            wbyte(b, 1'b1);
        end
        end_test("long_write");
        // foreign address in both directions stays unanswered
        for (k = 0; k < 2; k++) begin
            cmd(5'b10000, 8'h00);
            wbyte({VSS_DEV_ADDR ^ 7'h01, k[0]}, 1'b0);
            wbyte(8'($urandom), 1'b0);
            end_test("foreign_address");
        end
        rq.delete();
        finish_test;
    end
endmodule // voice_store_serial_slave_tb_top
